// File: shared/adc_port_pkg.sv
// Purpose: Constants for the two-input converter serial port
// Assumes: 10-bit codes, APB registers one aligned 32-bit word each
// Notes:   Frame positions count serial clock rises after the start bit
package adc_port_pkg;

   // Register byte offsets
   localparam logic [7:0] INPUT_A_OFFSET  = 8'h00;
   localparam logic [7:0] INPUT_B_OFFSET  = 8'h04;
   localparam logic [7:0] STATUS_OFFSET   = 8'h08;

   // Reset values
   localparam logic [9:0] INPUT_RESET     = 10'h000;
   localparam logic [9:0] RESULT_RESET    = 10'h000;

   // Status register field positions
   localparam int RESULT_LSB_POS  = 0;
   localparam int BUSY_POS        = 10;
   localparam int STANDBY_POS     = 11;
   localparam int SAMPLING_POS    = 12;
   localparam int MODE_POS        = 13;
   localparam int POLARITY_POS    = 14;
   localparam int ORDER_POS       = 15;

   // Frame positions, in rises after the start bit
   localparam logic [4:0] POS_MODE        = 5'h01;
   localparam logic [4:0] POS_POLARITY    = 5'h02;
   localparam logic [4:0] POS_ORDER       = 5'h03;
   localparam logic [4:0] POS_MSB_FIRST   = 5'h04;
   localparam logic [4:0] POS_MSB_LAST    = 5'h0D;
   localparam logic [4:0] POS_LSB_LAST    = 5'h16;
   localparam logic [4:0] POS_MAX         = 5'h1F;

   // Port states
   typedef enum logic [1:0] {
      ST_LOCKED,
      ST_HUNT,
      ST_FRAME
   } port_state_type;

endpackage

// File: verilog/adc_serial_port.sv
// Purpose: Serial command and readout logic of a two-input 10-bit SAR
// Assumes: Serial pins asynchronous to pclk, sampled through two flops
// Notes:   Analog inputs modelled as APB-written codes
// Function
// - First high-input rise while selected starts frame
// - Select low at reset needs high-low first
// - Mode then polarity bit follow start bit
// - Mode/polarity pick single A/B or differential
// - Order bit high: MSB word, then zeros
// - Order bit low: add LSB-first copy, zeros
// - Sampling from second rise to third fall
// - Low null bit on order-bit falling edge
// - Ten result bits MSB first follow null
// - While selected, output changes only on clock falling edges
// - Low-input clocks before start bit ignored
// - Raising select aborts conversion and output
// - One result bit resolved per clock
// - Differential result clamps to 000h when negative
// - Code is straight binary of input/reference
// - Select high ends conversion, enters standby
`timescale 1ns/1ps

module adc_serial_port
   import adc_port_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link
   input  wire logic        sclk,
   input  wire logic        select_standby_n,
   input  wire logic        din,
   output logic             dout,
   output logic             dout_oe,
   // Status
   output logic             standby,
   output logic             sample_active
);

   ////////////////////////////////////////////////////////////////////////
   // Functions
   // Code of the chosen input configuration
   function automatic logic [9:0] select_code(
      input logic       mode_bit,
      input logic       pol_bit,
      input logic [9:0] code_a,
      input logic [9:0] code_b
   );
      logic [9:0] pos, neg;
      pos = pol_bit ? code_b : code_a;
      neg = pol_bit ? code_a : code_b;
      if (mode_bit)
         select_code = pos;
      else if (pos <= neg)
         select_code = 10'h000;
      else
         select_code = pos - neg;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [2:0]     sclk_sync_r;
   logic [1:0]     cs_sync_r;
   logic [1:0]     din_sync_r;
   logic           sclk_rise;
   logic           sclk_fall;
   logic           cs_n;
   logic           din_s;
   port_state_type state_r, state_nxt;
   logic [4:0]     pos_r, pos_nxt;
   logic           input_mode_bit_r, input_mode_bit_nxt;
   logic           polarity_r, polarity_nxt;
   logic           bit_order_select_r, bit_order_select_nxt;
   logic           sampling_r, sampling_nxt;
   logic [9:0]     target_r, target_nxt;
   logic [9:0]     sar_r, sar_nxt;
   logic [9:0]     result_r, result_nxt;
   logic           dout_r, dout_nxt;
   logic           dout_oe_r, dout_oe_nxt;
   logic           standby_r, standby_nxt;
   logic [9:0]     input_a_r, input_a_nxt;
   logic [9:0]     input_b_r, input_b_nxt;
   logic [31:0]    prdata_r, prdata_nxt;
   logic           pready_r, pready_nxt;
   logic           pslverr_r, pslverr_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Two flops per pin; third sclk stage for edge finding
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_sync_r <= 3'h0;
         cs_sync_r   <= 2'h0;  // Select assumed low
         din_sync_r  <= 2'h0;
      end
      else
      begin
         sclk_sync_r <= {sclk_sync_r[1:0], sclk};
         cs_sync_r   <= {cs_sync_r[0], select_standby_n};
         din_sync_r  <= {din_sync_r[0], din};
      end
   end
   // Edges seen on the second and third stages only
   assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
   assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
   assign cs_n      = cs_sync_r[1];
   assign din_s     = din_sync_r[1];

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer
   // Next state of the serial frame
   always_comb
   begin
      logic [3:0] idx;
      logic [9:0] guess;
      logic       bit_val;
      idx                  = 4'h0;
      guess                = 10'h000;
      bit_val              = 1'b0;
      state_nxt            = state_r;
      pos_nxt              = pos_r;
      input_mode_bit_nxt   = input_mode_bit_r;
      polarity_nxt         = polarity_r;
      bit_order_select_nxt = bit_order_select_r;
      sampling_nxt         = sampling_r;
      target_nxt           = target_r;
      sar_nxt              = sar_r;
      result_nxt           = result_r;
      dout_nxt             = dout_r;
      dout_oe_nxt          = ~cs_n & (state_r != ST_LOCKED);
      standby_nxt          = standby_r;
      unique case (state_r)
         ST_LOCKED:
         begin
            if (cs_n)
               state_nxt = ST_HUNT;
         end
         ST_HUNT:
         begin
            standby_nxt = cs_n;
            dout_nxt    = 1'b0;
            if (!cs_n && sclk_rise && din_s)
            begin
               state_nxt   = ST_FRAME;
               pos_nxt     = 5'h00;
               standby_nxt = 1'b0;
               sar_nxt     = 10'h000;
            end
         end
         ST_FRAME:
         begin
            if (cs_n)
            begin
               state_nxt    = ST_HUNT;
               sampling_nxt = 1'b0;
               standby_nxt  = 1'b1;
               dout_nxt     = 1'b0;
            end
            else if (sclk_rise)
            begin
               if (pos_r != POS_MAX)
                  pos_nxt = pos_r + 5'h01;
               if (pos_nxt == POS_MODE)
                  input_mode_bit_nxt = din_s;
               if (pos_nxt == POS_POLARITY)
               begin
                  polarity_nxt = din_s;
                  sampling_nxt = 1'b1;
               end
               if (pos_nxt == POS_ORDER)
                  bit_order_select_nxt = din_s;
            end
            // output moves on falling edges only
            else if (sclk_fall)
            begin
               if (pos_r == POS_ORDER)
               begin
                  sampling_nxt = 1'b0;
                  target_nxt   = select_code(input_mode_bit_r, polarity_r,
                                             input_a_r, input_b_r);
                  dout_nxt     = 1'b0;
               end
               else if (pos_r >= POS_MSB_FIRST && pos_r <= POS_MSB_LAST)
               begin
                  idx        = 4'(POS_MSB_LAST - pos_r);
                  guess      = sar_r | (10'h001 << idx);
                  bit_val    = (target_r >= guess);
                  sar_nxt    = bit_val ? guess : sar_r;
                  dout_nxt   = bit_val;
                  if (pos_r == POS_MSB_LAST)
                     result_nxt = bit_val ? guess : sar_r;
               end
               else if (pos_r > POS_MSB_LAST && pos_r <= POS_LSB_LAST
                        && !bit_order_select_r)
               begin
                  idx      = 4'(pos_r - POS_MSB_LAST);
                  dout_nxt = sar_r[idx];
               end
               else if (pos_r > POS_MSB_LAST)
                  dout_nxt = 1'b0;
            end
         end
      endcase
   end
   // Frame state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r            <= ST_LOCKED;
         pos_r              <= 5'h00;
         input_mode_bit_r   <= 1'b0;
         polarity_r         <= 1'b0;
         bit_order_select_r <= 1'b0;
         sampling_r         <= 1'b0;
         target_r           <= RESULT_RESET;
         sar_r              <= RESULT_RESET;
         result_r           <= RESULT_RESET;
         dout_r             <= 1'b0;
         dout_oe_r          <= 1'b0;
         standby_r          <= 1'b1;
      end
      else
      begin
         state_r            <= state_nxt;
         pos_r              <= pos_nxt;
         input_mode_bit_r   <= input_mode_bit_nxt;
         polarity_r         <= polarity_nxt;
         bit_order_select_r <= bit_order_select_nxt;
         sampling_r         <= sampling_nxt;
         target_r           <= target_nxt;
         sar_r              <= sar_nxt;
         result_r           <= result_nxt;
         dout_r             <= dout_nxt;
         dout_oe_r          <= dout_oe_nxt;
         standby_r          <= standby_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave
   // Answer prepared in setup, shown during the access cycle
   always_comb
   begin
      logic setup, access;
      setup       = psel & ~penable;
      access      = psel & penable & pready_r;
      input_a_nxt = input_a_r;
      input_b_nxt = input_b_r;
      pready_nxt  = setup;
      prdata_nxt  = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      if (setup)
      begin
         unique case (paddr)
            INPUT_A_OFFSET: prdata_nxt[9:0] = input_a_r;
            INPUT_B_OFFSET: prdata_nxt[9:0] = input_b_r;
            STATUS_OFFSET:
            begin
               prdata_nxt[RESULT_LSB_POS +: 10] = result_r;
               prdata_nxt[BUSY_POS]     = (state_r == ST_FRAME);
               prdata_nxt[STANDBY_POS]  = standby_r;
               prdata_nxt[SAMPLING_POS] = sampling_r;
               prdata_nxt[MODE_POS]     = input_mode_bit_r;
               prdata_nxt[POLARITY_POS] = polarity_r;
               prdata_nxt[ORDER_POS]    = bit_order_select_r;
            end
            default:        pslverr_nxt = 1'b1;
         endcase
      end
      // Writes commit at the access edge
      if (access && pwrite)
      begin
         if (paddr == INPUT_A_OFFSET)
            input_a_nxt = pwdata[9:0];
         if (paddr == INPUT_B_OFFSET)
            input_b_nxt = pwdata[9:0];
      end
   end

   // APB registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         input_a_r <= INPUT_RESET;
         input_b_r <= INPUT_RESET;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         input_a_r <= input_a_nxt;
         input_b_r <= input_b_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata        = prdata_r;
   assign pready        = pready_r;
   assign pslverr       = pslverr_r;
   assign dout          = dout_r;
   assign dout_oe       = dout_oe_r;
   assign standby       = standby_r;
   assign sample_active = sampling_r;

endmodule // adc_serial_port

// File: verif/adc_serial_port_sva.sv
// Purpose: Port checks for the converter serial port
// Assumes: Link clock period of eight pclk cycles
// Notes:   Pin edges reach the core two to three pclk later
`timescale 1ns/1ps

module adc_serial_port_chk
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Link and status
   input wire logic        sclk,
   input wire logic        select_standby_n,
   input wire logic        dout,
   input wire logic        dout_oe,
   input wire logic        standby,
   input wire logic        sample_active
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_apb_ready;
      1'b1 |-> pready == $past(psel && !penable);
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("pready not one cycle after setup");
   property p_slverr;
      pslverr |-> pready && prdata == 32'h00000000;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("error answer malformed");
   property p_idle;
      select_standby_n [*4] |-> standby && !dout_oe;
   endproperty
   a_idle: assert property (p_idle)
      else $error("not in standby while deselected");
   property p_abort;
      $rose(select_standby_n) |-> ##[1:4] !dout_oe && !dout;
   endproperty
   a_abort: assert property (p_abort)
      else $error("output not released on deselect");
   property p_dout_fall;
      !select_standby_n [*5] ##0 $changed(dout) |->
         ($past(sclk, 2) && !$past(sclk, 1)) ||
         ($past(sclk, 3) && !$past(sclk, 2)) ||
         ($past(sclk, 4) && !$past(sclk, 3));
   endproperty
   a_dout_fall: assert property (p_dout_fall)
      else $error("output changed away from a clock fall");
   property p_sample_len;
      $rose(sample_active) |-> sample_active [*8] ##1
         sample_active [*2] ##[1:4] !sample_active;
   endproperty
   a_sample_len: assert property (p_sample_len)
      else $error("sample window not one and a half clocks");
   property p_sample_start;
      $rose(sample_active) |->
         ($past(sclk, 1) && !$past(sclk, 2)) ||
         ($past(sclk, 2) && !$past(sclk, 3)) ||
         ($past(sclk, 3) && !$past(sclk, 4));
   endproperty
   a_sample_start: assert property (p_sample_start)
      else $error("sampling began away from a clock rise");
   property p_null;
      $fell(sample_active) && !select_standby_n |->
         ##[0:2] (dout_oe && !dout) [*4];
   endproperty
   a_null: assert property (p_null)
      else $error("null bit not low");
endmodule // adc_serial_port_chk

bind adc_serial_port adc_serial_port_chk u_chk (.pclk, .presetn, .psel,
   .penable, .prdata, .pready, .pslverr, .sclk, .select_standby_n, .dout,
   .dout_oe, .standby, .sample_active);

// File: verif/spi_host_model.sv
// Purpose: Serial host driving converter frames
// Assumes: Clock idles low, stands still between frames
// Notes:   Released output seen as inverse of last value
`timescale 1ns/1ps

module spi_host_model
(
   // Bench clock
   input  wire logic pclk,
   // Link
   output logic      sclk,
   output logic      select_standby_n,
   output logic      din,
   input  wire logic dout,
   input  wire logic dout_oe
);
   wire dout_pin = dout_oe ? dout : ~dout;

   initial
   begin
      sclk = 1'b0;
      din = 1'b0;
      select_standby_n = 1'b0;
   end

   // fast clock, falls drive, rises capture
   task automatic run(input logic [2:0] cfg, input int n,
                      output logic [23:0] cap);
      logic [6:0] tx;
      int         i;
      tx = {2'b00, 1'b1, cfg, 1'b0};
      cap = 24'h000000;
      @(posedge pclk);
      select_standby_n <= 1'b0;
      repeat (5) @(posedge pclk);
      // Eight bench clocks per link clock, changes right after an edge
      for (i = 0; i < n; i++)
      begin
         din <= (i < 7) ? tx[6 - i] : 1'b0;
         repeat (4) @(posedge pclk);
         sclk <= 1'b1;
         if (i >= 6 && i < 30) cap = {cap[22:0], dout_pin};
         repeat (4) @(posedge pclk);
         sclk <= 1'b0;
      end
      repeat (5) @(posedge pclk);
      select_standby_n <= 1'b1;
      repeat (10) @(posedge pclk);
   endtask
endmodule // spi_host_model

// File: verif/tb_adc_serial_port.sv
// Purpose: Self-checking bench for the converter serial port
// Assumes: APB answers with one access cycle
// Notes:   Status is read mid-frame while the host clocks
`timescale 1ns/1ps

module tb_adc_serial_port;
   import adc_port_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
   logic        penable = 1'b0, pwrite = 1'b0, e;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, r;
   logic        pready, pslverr, sclk, select_standby_n, din;
   logic        dout, dout_oe, standby, sample_active;
   logic [23:0] cap;
   logic [9:0]  res;
   logic [2:0]  cfg;
   int          errors = 0, compares = 0, i;

   always #20 pclk = ~pclk;

   adc_serial_port u_adc_serial_port (.pclk, .presetn, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .sclk,
      .select_standby_n, .din, .dout, .dout_oe, .standby, .sample_active);
   spi_host_model u_spi_host_model (.pclk, .sclk, .select_standby_n, .din,
      .dout, .dout_oe);

   task automatic check(input string nm, input logic [31:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // One APB transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Frame with a status read in its middle
   task automatic frame(input logic [2:0] c, input int n,
                        input logic [31:0] msk, xst);
      logic [31:0] st;
      logic        se;
      fork
         u_spi_host_model.run(c, n, cap);
         begin
            repeat (75) @(posedge pclk);
            apb(1'b0, STATUS_OFFSET, 32'h00000000, st, se);
            check("status mid", st & msk, xst);
         end
      join
   endtask

   function automatic logic [9:0] conv(logic m, p, logic [9:0] a, b);
      logic [9:0] hi, lo;
      hi = p ? b : a;
      lo = p ? a : b;
      if (m) return hi;
      return (hi > lo) ? hi - lo : 10'h000;
   endfunction

   function automatic logic [23:0] bits(logic [9:0] v, logic o);
      logic [23:0] w;
      int          k;
      w = {1'b0, v, 13'h0000};
      if (!o) for (k = 1; k < 10; k++) w[13 - k] = v[k];
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      frame(3'b100, 30, 32'h00000C00, 32'h00000800);
      apb(1'b0, INPUT_A_OFFSET, 32'h00000000, r, e);
      check("input a reset", r, {22'h000000, INPUT_RESET});
      apb(1'b1, STATUS_OFFSET, 32'h000003FF, r, e);
      apb(1'b0, STATUS_OFFSET, 32'h00000000, r, e);
      check("result reset", r & 32'h000003FF, {22'h000000, RESULT_RESET});
      apb(1'b0, 8'h0C, 32'h00000000, r, e);
      check("unmapped", {r[30:0], e}, 32'h00000001);
      apb(1'b1, INPUT_A_OFFSET, 32'h000002C6, r, e);
      apb(1'b1, INPUT_B_OFFSET, 32'h0000013B, r, e);
      apb(1'b0, INPUT_B_OFFSET, 32'h00000000, r, e);
      check("input b", r, 32'h0000013B);
      for (i = 0; i < 5; i++)
      begin
         cfg = {i[1], i[0], i[0]};
         if (i == 4) cfg = 3'b001;
         if (i == 4) apb(1'b1, INPUT_A_OFFSET, 32'h000003FF, r, e);
         if (i == 4) apb(1'b1, INPUT_B_OFFSET, 32'h00000000, r, e);
         res = (i == 4) ? 10'h3FF : conv(cfg[2], cfg[1], 10'h2C6, 10'h13B);
         frame(cfg, 30, 32'h0000FC00,
               {16'h0000, cfg[0], cfg[1], cfg[2], 13'h0400});
         check("frame bits", cap, bits(res, cfg[0]));
         apb(1'b0, STATUS_OFFSET, 32'h00000000, r, e);
         check("result", r & 32'h000003FF, res);
      end
      frame(3'b101, 12, 32'h00000400, 32'h00000400);
      check("upper bits", cap[5:0], {1'b0, 10'h3FF >> 5});
      apb(1'b0, STATUS_OFFSET, 32'h00000000, r, e);
      check("after abort", r & 32'h00000C00, 32'h00000800);
      finish_test;
   end

   // Watchdog
   initial
   begin
      #2000000;
      errors++;
      finish_test;
   end
endmodule // tb_adc_serial_port
